// [hw/nsx_pkg.sv]
// Purpose: Shared constants for the nibble swap / xor / direction load executor
// Assumes: 14-bit instruction words, 8-bit data path, four Q phases per cycle
// Notes: Opcode fields are compared against the top bits of the word
package nsx_pkg;
  localparam int NSX_IW = 14;
  localparam int NSX_DW = 8;
  localparam int NSX_AW = 7;
  localparam logic [5:0] NSX_OPC_SWAP = 6'h0e;
  localparam logic [5:0] NSX_OPC_XORF = 6'h06;
  localparam logic [5:0] NSX_OPC_XORL = 6'h3a;
  localparam logic [10:0] NSX_OPC_DIR = 11'h00c;
  localparam logic [2:0] NSX_DIR_MIN = 3'h5;
  localparam logic [2:0] NSX_DIR_MAX = 3'h7;
  localparam logic [7:0] NSX_ACC_RST = 8'h00;
  localparam logic [7:0] NSX_DIR_RST = 8'hff;
  localparam logic [7:0] NSX_FILE_RST = 8'h00;
  localparam logic [1:0] NSX_Q_RST = 2'h0;
  typedef enum logic [1:0] {NSX_Q1, NSX_Q2, NSX_Q3, NSX_Q4} nsx_phase_t;
  typedef enum logic [2:0] {NSX_OP_NONE, NSX_OP_SWAP, NSX_OP_XORF, NSX_OP_XORL, NSX_OP_DIR} nsx_op_t;
endpackage

// [hw/nsx_file_if.sv]
`timescale 1ns/1ps
// Purpose: File register port between executor and its register file
// Assumes: Read is combinational, write is taken on the clock
// Notes: One modport per side
interface nsx_file_if;
  logic [6:0] addr;
  logic [7:0] rdata;
  logic [7:0] wdata;
  logic we;
  modport exec (output addr, output wdata, output we, input rdata);
  modport store (input addr, input wdata, input we, output rdata);
endinterface

// [hw/nsx_file_regs.sv]
`timescale 1ns/1ps
// Purpose: Small data file register array
// Assumes: Writes land at the clock edge of the write phase
// Notes: Entries clear on reset; costs a reset per flop but keeps every file result predictable
module nsx_file_regs import nsx_pkg::*; #(
  parameter int DEPTH = 128
) (
  input wire logic core_clk,
  input wire logic rst_n,
  nsx_file_if.store fport
);
  logic [NSX_DW-1:0] mem_r [DEPTH];

  // One flop group per entry; an entry takes the write strobe when its address matches
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_r[g] <= NSX_FILE_RST;
      end else if (fport.we && fport.addr == NSX_AW'(g)) begin
        mem_r[g] <= fport.wdata;
      end
    end
  end

  // Combinational read so the read phase sees the value at once
  assign fport.rdata = mem_r[fport.addr];
endmodule

// [hw/nsx_exec.sv]
`timescale 1ns/1ps
// Purpose: Decode and execute swap, xor and direction load instructions
// Assumes: instr is held stable for a whole instruction cycle
// Notes: One instruction per four core clocks; other opcodes act as no-ops
module nsx_exec import nsx_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NSX_IW-1:0] instr,
  output logic [NSX_DW-1:0] acc,
  output logic zero_flag,
  output logic [NSX_DW-1:0] dir_a,
  output logic [NSX_DW-1:0] dir_b,
  output logic [NSX_DW-1:0] dir_c,
  output logic cycle_start
);
  nsx_file_if fbus();
  nsx_phase_t q_r;
  nsx_op_t op_r;
  logic [NSX_IW-1:0] ir_r;
  logic [NSX_DW-1:0] opnd_r;
  logic [NSX_DW-1:0] res_r;
  logic [NSX_DW-1:0] acc_r;
  logic zero_r;
  logic [NSX_DW-1:0] dir_r [3];
  nsx_op_t dec_op;
  logic dest_file;

  nsx_file_regs u_file (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fport(fbus)
  );

  // Phase counter walks Q1..Q4 and wraps
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= NSX_Q1;
    end else begin
      q_r <= nsx_phase_t'(q_r + 2'h1);
    end
  end

  // Decode the word; direction load only for operands 5 to 7
  always_comb begin
    dec_op = NSX_OP_NONE;
    if (instr[13:8] == NSX_OPC_SWAP) begin
      dec_op = NSX_OP_SWAP;
    end else if (instr[13:8] == NSX_OPC_XORF) begin
      dec_op = NSX_OP_XORF;
    end else if (instr[13:8] == NSX_OPC_XORL) begin
      dec_op = NSX_OP_XORL;
    end else if (instr[13:3] == NSX_OPC_DIR && instr[2:0] >= NSX_DIR_MIN && instr[2:0] <= NSX_DIR_MAX) begin
      dec_op = NSX_OP_DIR;
    end
  end

  // Latch decode in Q1 so later phases ignore a changing input
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= NSX_OP_NONE;
      ir_r <= '0;
    end else if (q_r == NSX_Q1) begin
      op_r <= dec_op;
      ir_r <= instr;
    end
  end

  // Operand fetch in Q2: literal or file register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opnd_r <= '0;
    end else if (q_r == NSX_Q2) begin
      opnd_r <= (op_r == NSX_OP_XORL) ? ir_r[7:0] : fbus.rdata;
    end
  end

  // Compute in Q3
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_r <= '0;
    end else if (q_r == NSX_Q3) begin
      case (op_r)
        NSX_OP_SWAP: res_r <= {opnd_r[3:0], opnd_r[7:4]};
        NSX_OP_XORF, NSX_OP_XORL: res_r <= acc_r ^ opnd_r;
        default: res_r <= acc_r;
      endcase
    end
  end

  assign dest_file = ir_r[7] && (op_r == NSX_OP_SWAP || op_r == NSX_OP_XORF);
  assign fbus.addr = ir_r[6:0];
  assign fbus.wdata = res_r;
  // File write only in Q4 with destination bit set
  assign fbus.we = (q_r == NSX_Q4) && dest_file;

  // Accumulator write in Q4 when destination is the accumulator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= NSX_ACC_RST;
    end else if (q_r == NSX_Q4 && !dest_file &&
                 (op_r == NSX_OP_SWAP || op_r == NSX_OP_XORF || op_r == NSX_OP_XORL)) begin
      acc_r <= res_r;
    end
  end

  // Zero flag: only the two xor forms touch it; swap leaves it alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_r <= 1'b0;
    end else if (q_r == NSX_Q4 && (op_r == NSX_OP_XORF || op_r == NSX_OP_XORL)) begin
      zero_r <= (res_r == 8'h00);
    end
  end

  // Direction registers, index = operand minus five
  for (genvar i = 0; i < 3; i++) begin : g_dir
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        dir_r[i] <= NSX_DIR_RST;
      end else if (q_r == NSX_Q4 && op_r == NSX_OP_DIR && ir_r[2:0] == NSX_DIR_MIN + 3'(i)) begin
        dir_r[i] <= acc_r;
      end
    end
  end

  assign acc = acc_r;
  assign zero_flag = zero_r;
  assign dir_a = dir_r[0];
  assign dir_b = dir_r[1];
  assign dir_c = dir_r[2];
  assign cycle_start = (q_r == NSX_Q1);

  // Swap leaves zero flag intact
  chk_swap_keeps_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4 && op_r == NSX_OP_SWAP) |=> $stable(zero_r))
    else $error("swap changed zero flag");

  // Swap result equals nibble exchange of the fetched operand
  chk_swap_result: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q3 && op_r == NSX_OP_SWAP) |=> res_r == {$past(opnd_r[3:0]), $past(opnd_r[7:4])})
    else $error("swap result wrong");

  // File destination never writes accumulator
  chk_dest_file: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4 && dest_file) |=> $stable(acc_r))
    else $error("accumulator written with file destination");

  sequence s_q1_to_q4;
    q_r == NSX_Q1 ##1 q_r == NSX_Q2 ##1 q_r == NSX_Q3 ##1 q_r == NSX_Q4;
  endsequence

  // Phases run in strict order
  chk_phase_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q1) |-> s_q1_to_q4)
    else $error("phase order broken");

  // File write only in the fourth phase
  chk_write_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
    fbus.we |-> q_r == NSX_Q4)
    else $error("file write outside write phase");

  // Direction load copies accumulator
  chk_dir_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4 && op_r == NSX_OP_DIR && ir_r[2:0] == 3'h6) |=> dir_r[1] == $past(acc_r))
    else $error("direction load wrong");

  // Literal xor result lands in accumulator
  chk_xorl_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q3 && op_r == NSX_OP_XORL) |=> ##1 acc_r == ($past(acc_r, 2) ^ $past(ir_r[7:0], 2)))
    else $error("literal xor result wrong");

  // File xor with file destination writes the xor value
  chk_xorf_file: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4 && op_r == NSX_OP_XORF && ir_r[7]) |-> fbus.we && fbus.wdata == (acc_r ^ fbus.rdata))
    else $error("file xor write wrong");

  // Zero flag tracks the xor result
  chk_zero_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4 && (op_r == NSX_OP_XORF || op_r == NSX_OP_XORL)) |=> zero_r == ($past(res_r) == 8'h00))
    else $error("zero flag wrong");

  // A new word is only taken in the first phase
  chk_decode_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q1) |=> op_r == $past(dec_op))
    else $error("decode not latched in first phase");

  // After the write phase the next cycle starts
  chk_phase_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4) |=> (q_r == NSX_Q1 && cycle_start))
    else $error("phase did not wrap to first");

  // Swap with accumulator destination delivers the exchanged file value
  chk_swap_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4 && op_r == NSX_OP_SWAP && !ir_r[7]) |=>
      acc_r == {$past(fbus.rdata[3:0]), $past(fbus.rdata[7:4])})
    else $error("swap to accumulator wrong");

  // File xor with accumulator destination
  chk_xorf_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q_r == NSX_Q4 && op_r == NSX_OP_XORF && !ir_r[7]) |=> acc_r == ($past(acc_r) ^ $past(fbus.rdata)))
    else $error("file xor to accumulator wrong");

  // Literal xor, direction load and no-ops never touch the file
  chk_no_file_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (op_r == NSX_OP_XORL || op_r == NSX_OP_DIR || op_r == NSX_OP_NONE) |-> !fbus.we)
    else $error("file written by a non-file instruction");

  sequence s_dir_write;
    q_r == NSX_Q4 && op_r == NSX_OP_DIR;
  endsequence

  // Direction load leaves accumulator and zero flag alone
  chk_dir_no_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_dir_write |=> $stable(acc_r) && $stable(zero_r))
    else $error("direction load changed accumulator or flag");

  // Direction registers move only on a direction load
  chk_dir_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(q_r == NSX_Q4 && op_r == NSX_OP_DIR) |=> $stable(dir_r[0]) && $stable(dir_r[1]) && $stable(dir_r[2]))
    else $error("direction register changed without a load");
endmodule

// [dv/nsx_exec_tb.sv]
// Purpose: Self-checking bench for the swap / xor / direction load executor
// Assumes: One instruction per four clocks, driven 2 ns after each rising edge
// Notes: File entries clear on reset; file results are judged through later accumulator moves
`timescale 1ns/1ps
module nsx_exec_tb import nsx_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] acc, dir_a, dir_b, dir_c;
  logic zero_flag, cycle_start;
  int fail_count = 0;
  int compares = 0;

  nsx_exec dut (.core_clk(core_clk), .rst_n(rst_n), .instr(instr), .acc(acc), .zero_flag(zero_flag),
    .dir_a(dir_a), .dir_b(dir_b), .dir_c(dir_c), .cycle_start(cycle_start));

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  task automatic tally_and_finish();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for Q1 under a bound, presents the word, lets all four phases pass
  task automatic exec(input logic [13:0] w);
    int n;
    n = 0;
    while (cycle_start !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    if (cycle_start !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    instr = w;
    repeat (4) @(posedge core_clk);
    #2;
  endtask

  task automatic t_reset();
    chk({zero_flag, acc}, 9'h000);
    chk({cycle_start, dir_a}, {1'b1, NSX_DIR_RST});
    chk({dir_b[0], dir_c}, {NSX_DIR_RST[0], NSX_DIR_RST});
    $display("test reset done");
  endtask

  // Result must not show before the write phase, then lands on the fourth edge
  task automatic t_xorl();
    instr = {NSX_OPC_XORL, 8'hb5};
    repeat (3) @(posedge core_clk);
    #2;
    chk({cycle_start, acc}, 9'h000);
    @(posedge core_clk);
    #2;
    chk({zero_flag, acc}, {1'b0, 8'hb5});
    exec({NSX_OPC_XORL, 8'haf});
    chk({zero_flag, acc}, {1'b0, 8'h1a});
    exec({NSX_OPC_XORL, 8'h1a});
    chk({zero_flag, acc}, {1'b1, 8'h00});
    $display("test literal xor done");
  endtask

  // Operand 4 is refused; 5..7 each pick one direction register
  task automatic t_dir();
    logic [7:0] m, ea, eb, ec;
    logic z;
    m = 8'h00;
    ea = NSX_DIR_RST;
    eb = NSX_DIR_RST;
    ec = NSX_DIR_RST;
    for (int i = 4; i < 8; i++) begin
      exec({NSX_OPC_XORL, 8'h11});
      m = m ^ 8'h11;
      z = (m == 8'h00);
      exec({NSX_OPC_DIR, i[2:0]});
      if (i == 5) ea = m;
      if (i == 6) eb = m;
      if (i == 7) ec = m;
      chk({zero_flag, dir_a}, {z, ea});
      chk({1'b0, dir_b}, {1'b0, eb});
      chk({1'b0, dir_c}, {1'b0, ec});
    end
    $display("test direction load done");
  endtask

  // Destination one leaves the accumulator; file values show through later destination-zero reads
  task automatic t_file();
    exec({NSX_OPC_XORL, 8'h5a});
    exec({NSX_OPC_XORF, 1'b1, 7'h0c});
    chk({zero_flag, acc}, {1'b0, 8'h5a});
    exec({NSX_OPC_SWAP, 1'b1, 7'h0c});
    chk({zero_flag, acc}, {1'b0, 8'h5a});
    exec({NSX_OPC_XORF, 1'b0, 7'h0c});
    chk({zero_flag, acc}, {1'b0, 8'hff});
    exec({NSX_OPC_XORL, 8'hff});
    exec({NSX_OPC_SWAP, 1'b0, 7'h0c});
    chk({zero_flag, acc}, {1'b1, 8'h5a});
    exec({NSX_OPC_XORF, 1'b1, 7'h0d});
    exec({NSX_OPC_XORF, 1'b0, 7'h0d});
    chk({zero_flag, acc}, {1'b1, 8'h00});
    exec(14'h3f00);
    chk({zero_flag, acc}, {1'b1, 8'h00});
    $display("test file ops done");
  endtask

  // Mid-run reset restores outputs and file entries; the first word goes in before the first edge
  task automatic t_rerun();
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #2;
    chk({zero_flag, acc}, 9'h000);
    chk({cycle_start, dir_a}, {1'b1, NSX_DIR_RST});
    chk({1'b1, dir_b}, {1'b1, NSX_DIR_RST});
    chk({1'b1, dir_c}, {1'b1, NSX_DIR_RST});
    rst_n = 1'b1;
    exec({NSX_OPC_XORF, 1'b0, 7'h0c});
    chk({zero_flag, acc}, {1'b1, 8'h00});
    $display("test mid-run reset done");
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    t_reset();
    t_xorl();
    t_dir();
    t_file();
    t_rerun();
    tally_and_finish();
  end
endmodule
